/* verilog/bus_cycle_map.svh */
// register offsets, field positions, reset values and timing counts of the bus cycle timer
// Operation
// - Each bus cycle lasts the larger of the minimum slave interval and the summed poll time plus refresh overhead.
// - The summed poll time adds each slave's poll time plus the master turnaround, then the refresh overhead once.
// - When the minimum interval is the larger, received data moves to host buffer memory within that interval.
// - A station's poll time is request frame time plus its maximum response delay plus response frame time.
// - A request frame is (output bytes + 9) characters of 11 bits at the link speed.
// - One bit time is the reciprocal of the link speed, so bit-time delays scale with the rate; the code rounds clocks per bit down, exact only at 500 kbit/s.
// - Master turnaround is 70 bit times up to 187.5 kbit/s, 150 at 500 kbit/s and 200 at 1.5 Mbit/s.
// - Master turnaround is 250 bit times at 3 Mbit/s, 450 at 6 Mbit/s and 800 at 12 Mbit/s.
// - Refresh overhead is 5.50 ms plus 150 us for each configured slave.
// - The result word reports the accepted condition, 0 for OR and 1 for AND.
`ifndef BUS_CYCLE_MAP_SVH
`define BUS_CYCLE_MAP_SVH
`define ADDR_COND_SETTING 16'h5C60
`define ADDR_TARGET_SETTING 16'h5C61
`define ADDR_COND_RESULT 16'h5C70
`define ADDR_TARGET_RESULT 16'h5C71
`define TARGET_WORDS 8
`define TARGET_LAST_MASK 16'h0FFF
`define REG_RESET 16'h0000
`define FRAME_OVERHEAD_CHARS 9
`define BITS_PER_CHAR 11
`define TURN_LOW 70
`define TURN_500K 150
`define TURN_1M5 200
`define TURN_3M 250
`define TURN_6M 450
`define TURN_12M 800
`define CLK_HZ 50000000
`define REFRESH_BASE_US 5500
`define REFRESH_SLAVE_US 150
`define CLKS_PER_US (`CLK_HZ / 1000000)
`define REFRESH_BASE_CLKS (`REFRESH_BASE_US * `CLKS_PER_US)
`define REFRESH_SLAVE_CLKS (`REFRESH_SLAVE_US * `CLKS_PER_US)
`endif

/* verilog/bus_cycle_pkg.sv */
// types shared by the bus cycle timer
package bus_cycle_pkg;
  typedef enum logic [3:0] {
    SPEED_9K6 = 4'h0,
    SPEED_19K2 = 4'h1,
    SPEED_93K75 = 4'h2,
    SPEED_187K5 = 4'h3,
    SPEED_500K = 4'h4,
    SPEED_1M5 = 4'h5,
    SPEED_3M = 4'h6,
    SPEED_6M = 4'h7,
    SPEED_12M = 4'h8
  } link_speed_type;

  typedef struct packed {
    logic [7:0] out_bytes;
    logic [7:0] in_bytes;
    logic [15:0] max_resp_bits;
  } slave_cfg_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } host_req_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_POLL = 4'b0010,
    ST_REFRESH = 4'b0100,
    ST_WAIT = 4'b1000
  } cycle_state_type;
endpackage

/* verilog/bit_time_gen.sv */
// bit-time tick generator: one tick per link bit period
`include "bus_cycle_map.svh"
module bit_time_gen
  import bus_cycle_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire link_speed_type speed_i,
  input wire logic restart_i,
  output logic tick_o
);
  logic [12:0] div_reg;
  logic [12:0] div_next;
  logic [12:0] period;

  // clocks per bit rounded down; only 500 kbit/s is exact at 50 MHz
  function automatic logic [12:0] period_of(input link_speed_type s);
    case (s)
      SPEED_9K6: period_of = 13'(`CLK_HZ / 9600);
      SPEED_19K2: period_of = 13'(`CLK_HZ / 19200);
      SPEED_93K75: period_of = 13'(`CLK_HZ / 93750);
      SPEED_187K5: period_of = 13'(`CLK_HZ / 187500);
      SPEED_500K: period_of = 13'(`CLK_HZ / 500000);
      SPEED_1M5: period_of = 13'(`CLK_HZ / 1500000);
      SPEED_3M: period_of = 13'(`CLK_HZ / 3000000);
      SPEED_6M: period_of = 13'(`CLK_HZ / 6000000);
      SPEED_12M: period_of = 13'(`CLK_HZ / 12000000);
      default: period_of = 13'(`CLK_HZ / 9600);
    endcase
  endfunction

  assign period = period_of(speed_i);

  // count one bit period, tick on wrap; restart aligns the first slot to a whole bit period
  always_comb
  begin
    div_next = div_reg;
    if (restart_i)
      div_next = 13'h0000;
    else if (div_reg >= period - 13'h0001)
      div_next = 13'h0000;
    else
      div_next = div_reg + 13'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_reg <= 13'h0000;
    else if (ce_i)
      div_reg <= div_next;
  end

  assign tick_o = ce_i && (div_reg >= period - 13'h0001);
endmodule

/* verilog/bus_cycle_timer.sv */
// bus cycle timer of the fieldbus master: polling sequence, cycle length, switch setting words
`include "bus_cycle_map.svh"
module bus_cycle_timer
  import bus_cycle_pkg::*;
#(
  parameter int NUM_SLAVES = 4,
  parameter int INTERVAL_CLKS_PER_UNIT = 5000
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire link_speed_type speed_i,
  input wire logic [15:0] min_slave_interval_i,
  input wire logic [NUM_SLAVES-1:0] slave_en_i,
  input wire slave_cfg_type [NUM_SLAVES-1:0] slave_cfg_i,
  input wire logic run_i,
  input wire host_req_type host_req_i,
  input wire logic host_rd_i,
  output logic [15:0] host_rdata_o,
  output logic poll_o,
  output logic [7:0] poll_station_o,
  output logic refresh_o,
  output logic cycle_start_o,
  output logic [31:0] bus_cycle_time_o
);
  initial
  begin
    if (NUM_SLAVES < 1 || NUM_SLAVES > 124)
      $error("NUM_SLAVES out of range");
    if (INTERVAL_CLKS_PER_UNIT < 1)
      $error("INTERVAL_CLKS_PER_UNIT must be positive");
  end

  localparam int SW = (NUM_SLAVES > 1) ? $clog2(NUM_SLAVES) : 1;

  logic run_s1_reg;
  logic run_s2_reg;
  logic bit_tick;
  cycle_state_type state_reg;
  cycle_state_type state_next;
  logic [SW-1:0] idx_reg;
  logic [SW-1:0] idx_next;
  logic [31:0] bits_left_reg;
  logic [31:0] bits_left_next;
  logic [31:0] refresh_left_reg;
  logic [31:0] refresh_left_next;
  logic [31:0] cycle_cnt_reg;
  logic [31:0] cycle_cnt_next;
  logic [31:0] bus_cycle_reg;
  logic [31:0] bus_cycle_next;
  logic [31:0] interval_clks;
  logic [31:0] refresh_clks;
  logic [7:0] n_active;
  logic first_found;
  logic [SW-1:0] first_idx;
  logic next_found;
  logic [SW-1:0] next_idx;
  logic [15:0] cond_set_reg;
  logic [15:0] cond_set_next;
  logic [15:0] tgt_set_reg [`TARGET_WORDS];
  logic [15:0] tgt_set_next [`TARGET_WORDS];
  logic [15:0] cond_res_reg;
  logic [15:0] cond_res_next;
  logic [15:0] tgt_res_reg [`TARGET_WORDS];
  logic [15:0] tgt_res_next [`TARGET_WORDS];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic run_rise;

  // master turnaround per link rate, in bit times
  function automatic logic [31:0] turnaround(input link_speed_type s);
    case (s)
      SPEED_500K: turnaround = 32'(`TURN_500K);
      SPEED_1M5: turnaround = 32'(`TURN_1M5);
      SPEED_3M: turnaround = 32'(`TURN_3M);
      SPEED_6M: turnaround = 32'(`TURN_6M);
      SPEED_12M: turnaround = 32'(`TURN_12M);
      default: turnaround = 32'(`TURN_LOW);
    endcase
  endfunction

  // bit length of a frame carrying the given payload bytes
  function automatic logic [31:0] frame_bits(input logic [7:0] nbytes);
    frame_bits = (32'(nbytes) + 32'(`FRAME_OVERHEAD_CHARS)) * 32'(`BITS_PER_CHAR);
  endfunction

  // whole poll slot of one station, turnaround included
  function automatic logic [31:0] slot_bits(input slave_cfg_type c, input link_speed_type s);
    slot_bits = frame_bits(c.out_bytes) + 32'(c.max_resp_bits)
      + frame_bits(c.in_bytes) + turnaround(s);
  endfunction

  bit_time_gen u_bit_time_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .speed_i(speed_i),
    .restart_i(run_rise),
    .tick_o(bit_tick)
  );

  // count slaves and find first and next enabled stations in ascending order
  always_comb
  begin
    n_active = 8'h00;
    first_found = 1'b0;
    first_idx = '0;
    next_found = 1'b0;
    next_idx = '0;
    for (int i = 0; i < NUM_SLAVES; i++)
    begin
      if (slave_en_i[i])
      begin
        n_active = n_active + 8'h01;
        if (!first_found)
        begin
          first_found = 1'b1;
          first_idx = SW'(i);
        end
        if (!next_found && SW'(i) > idx_reg)
        begin
          next_found = 1'b1;
          next_idx = SW'(i);
        end
      end
    end
  end

  assign refresh_clks = 32'(`REFRESH_BASE_CLKS)
    + 32'(n_active) * 32'(`REFRESH_SLAVE_CLKS);
  assign interval_clks = 32'(min_slave_interval_i) * 32'(INTERVAL_CLKS_PER_UNIT);
  assign run_rise = run_s2_reg && (state_reg == ST_IDLE);

  // polling sequence: poll each enabled slave, refresh, pad to the minimum interval
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    bits_left_next = bits_left_reg;
    refresh_left_next = refresh_left_reg;
    cycle_cnt_next = cycle_cnt_reg + 32'h0000_0001;
    bus_cycle_next = bus_cycle_reg;
    case (state_reg)
      ST_IDLE:
      begin
        cycle_cnt_next = 32'h0000_0000;
        if (run_s2_reg)
        begin
          cycle_cnt_next = 32'h0000_0001;
          if (first_found)
          begin
            state_next = ST_POLL;
            idx_next = first_idx;
            bits_left_next = slot_bits(slave_cfg_i[first_idx], speed_i);
          end
          else
          begin
            state_next = ST_REFRESH;
            refresh_left_next = refresh_clks;
          end
        end
      end
      ST_POLL:
      begin
        if (bit_tick)
        begin
          if (bits_left_reg > 32'h0000_0001)
            bits_left_next = bits_left_reg - 32'h0000_0001;
          else if (next_found)
          begin
            idx_next = next_idx;
            bits_left_next = slot_bits(slave_cfg_i[next_idx], speed_i);
          end
          else
          begin
            state_next = ST_REFRESH;
            refresh_left_next = refresh_clks;
          end
        end
      end
      ST_REFRESH:
      begin
        // refresh always ends before the cycle closes; data lands inside the interval only when polls plus refresh fit in it
        if (refresh_left_reg > 32'h0000_0001)
          refresh_left_next = refresh_left_reg - 32'h0000_0001;
        else
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cycle_cnt_reg >= interval_clks)
        begin
          bus_cycle_next = cycle_cnt_reg + 32'h0000_0001;
          cycle_cnt_next = 32'h0000_0000;
          state_next = ST_IDLE;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    if (!run_s2_reg && state_reg == ST_WAIT)
      state_next = ST_IDLE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      bits_left_reg <= 32'h0000_0000;
      refresh_left_reg <= 32'h0000_0000;
      cycle_cnt_reg <= 32'h0000_0000;
      bus_cycle_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      run_s1_reg <= run_i;
      run_s2_reg <= run_s1_reg;
      state_reg <= state_next;
      idx_reg <= idx_next;
      bits_left_reg <= bits_left_next;
      refresh_left_reg <= refresh_left_next;
      cycle_cnt_reg <= cycle_cnt_next;
      bus_cycle_reg <= bus_cycle_next;
    end
  end

  // setting words: writes ignored while exchange runs; results latched at start
  always_comb
  begin
    cond_set_next = cond_set_reg;
    cond_res_next = cond_res_reg;
    rdata_next = rdata_reg;
    for (int w = 0; w < `TARGET_WORDS; w++)
    begin
      tgt_set_next[w] = tgt_set_reg[w];
      tgt_res_next[w] = tgt_res_reg[w];
    end
    if (host_req_i.we && !run_s2_reg)
    begin
      if (host_req_i.addr == `ADDR_COND_SETTING)
        cond_set_next = host_req_i.wdata;
      for (int w = 0; w < `TARGET_WORDS; w++)
        if (host_req_i.addr == `ADDR_TARGET_SETTING + 16'(w))
          tgt_set_next[w] = (w == `TARGET_WORDS - 1) ?
            (host_req_i.wdata & `TARGET_LAST_MASK) : host_req_i.wdata;
    end
    if (run_rise)
    begin
      cond_res_next = cond_set_reg;
      for (int w = 0; w < `TARGET_WORDS; w++)
        tgt_res_next[w] = tgt_set_reg[w];
    end
    if (host_rd_i)
    begin
      rdata_next = 16'h0000;
      if (host_req_i.addr == `ADDR_COND_SETTING)
        rdata_next = cond_set_reg;
      if (host_req_i.addr == `ADDR_COND_RESULT)
        rdata_next = cond_res_reg;
      for (int w = 0; w < `TARGET_WORDS; w++)
      begin
        if (host_req_i.addr == `ADDR_TARGET_SETTING + 16'(w))
          rdata_next = tgt_set_reg[w];
        if (host_req_i.addr == `ADDR_TARGET_RESULT + 16'(w))
          rdata_next = tgt_res_reg[w];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cond_set_reg <= `REG_RESET;
      cond_res_reg <= `REG_RESET;
      rdata_reg <= `REG_RESET;
      for (int w = 0; w < `TARGET_WORDS; w++)
      begin
        tgt_set_reg[w] <= `REG_RESET;
        tgt_res_reg[w] <= `REG_RESET;
      end
    end
    else if (ce_i)
    begin
      cond_set_reg <= cond_set_next;
      cond_res_reg <= cond_res_next;
      rdata_reg <= rdata_next;
      for (int w = 0; w < `TARGET_WORDS; w++)
      begin
        tgt_set_reg[w] <= tgt_set_next[w];
        tgt_res_reg[w] <= tgt_res_next[w];
      end
    end
  end

  // status outputs
  assign host_rdata_o = rdata_reg;
  assign poll_o = (state_reg == ST_POLL);
  assign poll_station_o = 8'(idx_reg) + 8'h01;
  assign refresh_o = (state_reg == ST_REFRESH);
  assign cycle_start_o = run_rise && ce_i;
  assign bus_cycle_time_o = bus_cycle_reg;
endmodule

/* bench/cycle_checks_assertions.sv */
// concurrent checks on the bus cycle timer ports
`include "bus_cycle_map.svh"
module cycle_checks #(
  parameter int NUM_SLAVES = 4,
  parameter int INTERVAL_CLKS_PER_UNIT = 5000
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] min_slave_interval_i,
  input wire logic [NUM_SLAVES-1:0] slave_en_i,
  input wire logic poll_o,
  input wire logic [7:0] poll_station_o,
  input wire logic refresh_o,
  input wire logic cycle_start_o,
  input wire logic [31:0] bus_cycle_time_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rcnt_reg;
  logic [31:0] rcnt_next;
  logic [31:0] rexp;
  // refresh length counter; assumes the clock enable stays high
  always_comb
    rcnt_next = refresh_o ? rcnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk_i)
    rcnt_reg <= rst_i ? 32'h0 : rcnt_next;
  assign rexp = 32'(`REFRESH_BASE_CLKS) + 32'($countones(slave_en_i)) * 32'(`REFRESH_SLAVE_CLKS);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pulse;
    cycle_start_o |=> !cycle_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_first;
    cycle_start_o && (|slave_en_i) |=> poll_o;
  endproperty
  a_first: assert property (p_first) else $error("no poll after start");
  property p_order;
    poll_o && $past(poll_o) && poll_station_o != $past(poll_station_o)
      |-> poll_station_o > $past(poll_station_o);
  endproperty
  a_order: assert property (p_order) else $error("station order");
  property p_enabled;
    poll_o |-> poll_station_o != 8'h00 && slave_en_i[poll_station_o - 8'h01];
  endproperty
  a_enabled: assert property (p_enabled) else $error("polled station not configured");
  property p_excl;
    cycle_start_o |-> !poll_o && !refresh_o;
  endproperty
  a_excl: assert property (p_excl) else $error("start during poll or refresh");
  property p_after_poll;
    $rose(refresh_o) && (|slave_en_i) |-> $past(poll_o) || $past(poll_o, 2);
  endproperty
  a_after_poll: assert property (p_after_poll) else $error("refresh not after polls");
  property p_refresh_len;
    $fell(refresh_o) |-> rcnt_reg >= rexp && rcnt_reg <= rexp + 32'h2;
  endproperty
  a_refresh_len: assert property (p_refresh_len) else $error("refresh length");
  property p_ge_interval;
    $changed(bus_cycle_time_o)
      |-> bus_cycle_time_o >= 32'(min_slave_interval_i) * INTERVAL_CLKS_PER_UNIT;
  endproperty
  a_ge_interval: assert property (p_ge_interval) else $error("cycle shorter than interval");
  property p_hold;
    poll_o |-> $stable(bus_cycle_time_o);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle time moved while polling");
endmodule

/* bench/slave_stations.sv */
// stand-in for the polled slave stations: frame sizes and declared answer delay
module slave_stations
  import bus_cycle_pkg::*;
#(
  parameter int N = 3
)
(
  input wire logic [7:0] out_bytes_i [N],
  input wire logic [7:0] in_bytes_i [N],
  input wire logic [15:0] resp_bits_i [N],
  output slave_cfg_type [N-1:0] cfg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // each station answers with in_bytes+9 characters after its delay in bit times
  always_comb
  begin
    for (int i = 0; i < N; i++)
      cfg_o[i] = '{out_bytes_i[i], in_bytes_i[i], resp_bits_i[i]};
  end
endmodule

/* bench/testbench.sv */
// self-checking bench for the bus cycle timer
`include "bus_cycle_map.svh"
module testbench;
  import bus_cycle_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NS = 3;
  localparam int UNIT = 5;
  logic clk, rst, run, rd, poll, refr, cstart;
  link_speed_type spd;
  logic [15:0] min_ivl, rdata, d, cond, tgt;
  logic [NS-1:0] en;
  slave_cfg_type [NS-1:0] cfg;
  host_req_type req;
  logic [7:0] station;
  logic [31:0] bct, seed, tot;
  logic [7:0] ob [NS];
  logic [7:0] ib [NS];
  logic [15:0] rsp [NS];
  logic [15:0] regs [5] = '{`ADDR_COND_SETTING, `ADDR_TARGET_SETTING, `ADDR_COND_RESULT,
    `ADDR_TARGET_RESULT, 16'h1234};
  int failures, checks;
  int rates [9] = '{9600, 19200, 93750, 187500, 500000, 1500000, 3000000, 6000000, 12000000};
  int turns [9] = '{70, 70, 70, 70, 150, 200, 250, 450, 800};
  slave_stations #(.N(NS)) i_slaves (.out_bytes_i(ob), .in_bytes_i(ib), .resp_bits_i(rsp),
    .cfg_o(cfg));
  bus_cycle_timer #(.NUM_SLAVES(NS), .INTERVAL_CLKS_PER_UNIT(UNIT)) i_dut (.clk_i(clk),
    .rst_i(rst), .ce_i(1'b1), .speed_i(spd), .min_slave_interval_i(min_ivl), .slave_en_i(en),
    .slave_cfg_i(cfg),
    .run_i(run), .host_req_i(req), .host_rd_i(rd), .host_rdata_o(rdata), .poll_o(poll),
    .poll_station_o(station), .refresh_o(refr), .cycle_start_o(cstart), .bus_cycle_time_o(bct));
  // free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // slot in clocks: both frames, answer delay and turnaround, each bit rounded down to whole clocks
  function automatic int slot_clks(int i);
    int bits;
    bits = (int'(ob[i]) + 9) * 11 + int'(rsp[i]) + (int'(ib[i]) + 9) * 11 + turns[int'(spd)];
    return bits * (50000000 / rates[int'(spd)]);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks++;
    if (^got === 1'bx || got < exp || got > exp + tol)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{1'b1, a, v};
    @(posedge clk);
    req <= '{1'b0, a, v};
  endtask
  task automatic rd_word(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    req <= '{1'b0, a, 16'h0000};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    run <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // bounded wait for the start pulse; a hang counts as a mismatch
  task automatic wait_start();
    int n;
    n = 0;
    while (cstart !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 400000)
      begin
        failures++;
        report_and_stop();
      end
    end
  endtask
  // time each station slot and check the stations come in ascending configured order
  task automatic poll_slots();
    int n, cnt, nxt;
    logic [7:0] st;
    n = 0;
    cnt = 0;
    nxt = 0;
    st = 8'h00;
    while (refr !== 1'b1 && n < 200000)
    begin
      @(negedge clk);
      n++;
      if (cnt > 0 && (poll !== 1'b1 || station !== st))
      begin
        while (nxt < NS && !en[nxt]) nxt++;
        chk(st, nxt + 1, 0);
        chk(cnt, slot_clks(nxt), 3);
        nxt++;
        cnt = 0;
      end
      if (poll === 1'b1)
      begin
        st = station;
        cnt++;
      end
    end
    while (nxt < NS && !en[nxt]) nxt++;
    chk(nxt, NS, 0);
    if (n >= 200000) failures++;
  endtask
  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    rd = 1'b0;
    req = '0;
    spd = SPEED_12M;
    min_ivl = 16'h0010;
    en = '1;
    seed = 32'h00017E72;
    failures = 0;
    checks = 0;
    foreach (ob[i])
    begin
      ob[i] = 8'h00;
      ib[i] = 8'h00;
      rsp[i] = 16'h0000;
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, an unmapped place, and the fixed top bits of the last target word
    foreach (regs[k])
    begin
      rd_word(regs[k], d);
      chk(d, 32'h0, 0);
    end
    wr(`ADDR_TARGET_SETTING + 16'h0007, 16'hFFFF);
    rd_word(`ADDR_TARGET_SETTING + 16'h0007, d);
    chk(d, `TARGET_LAST_MASK, 0);
    // every speed from 187.5k up; slower ones would need over 140000 clocks per slot
    for (int s = 3; s <= 8; s++)
    begin
      @(posedge clk);
      spd <= link_speed_type'(s);
      en <= (s == 3) ? 3'b010 : 3'(rnd()) | 3'b001;
      for (int i = 0; i < NS; i++)
      begin
        ob[i] <= 8'(rnd() & 32'h3);
        ib[i] <= 8'(rnd() & 32'h3);
        rsp[i] <= 16'(rnd() & 32'hF);
      end
      cond = 16'(rnd());
      tgt = 16'(rnd());
      wr(`ADDR_COND_SETTING, cond);
      wr(`ADDR_TARGET_SETTING, tgt);
      tot = `REFRESH_BASE_CLKS + $countones(en) * `REFRESH_SLAVE_CLKS;
      for (int i = 0; i < NS; i++)
        if (en[i]) tot += slot_clks(i);
      @(posedge clk);
      run <= 1'b1;
      wait_start();
      poll_slots();
      rd_word(`ADDR_COND_RESULT, d);
      chk(d, cond, 0);
      rd_word(`ADDR_TARGET_RESULT, d);
      chk(d, tgt, 0);
      wr(`ADDR_COND_SETTING, ~cond);
      rd_word(`ADDR_COND_SETTING, d);
      chk(d, cond, 0);
      // abort in mid-refresh except on the last speed, which runs the cycle out
      if (s < 8)
        do_reset();
    end
    @(negedge clk);
    wait_start();
    repeat (3) @(negedge clk);
    chk(bct, tot, 16);
    report_and_stop();
  end
endmodule
bind bus_cycle_timer cycle_checks #(.NUM_SLAVES(NUM_SLAVES),
  .INTERVAL_CLKS_PER_UNIT(INTERVAL_CLKS_PER_UNIT))
  i_checks (.clk_i(clk_i), .rst_i(rst_i), .min_slave_interval_i(min_slave_interval_i),
  .slave_en_i(slave_en_i), .poll_o(poll_o), .poll_station_o(poll_station_o),
  .refresh_o(refresh_o), .cycle_start_o(cycle_start_o), .bus_cycle_time_o(bus_cycle_time_o));
